/* File: dv/sbtc_crystal_model.sv */
// crystal oscillator source feeding the timer's auxiliary input
`timescale 1ns/1ps
`default_nettype none
module sbtc_crystal_model
#(
    parameter int HALF = 5
)
(
    input wire logic mclk_i,
    input wire logic enable_i,
    output logic clk_o
);
    int cnt = 0;
    logic clk_q = 1'b0;
    assign clk_o = clk_q;
    // no sleep input: keeps swinging while enabled, stands low when shut off
    always @(posedge mclk_i)
    begin
        if (!enable_i)
        begin
            cnt <= 0;
            clk_q <= 1'b0;
        end
        else if (cnt == HALF - 1)
        begin
            cnt <= 0;
            clk_q <= ~clk_q;
        end
        else
            cnt <= cnt + 1;
    end
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// self-checking bench for the sixteen-bit timer/counter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int DIV = 2;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep = 1'b0, ext_pin = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, lfsr = 32'haeaa;
    logic pready, pslverr, xtal, osc_en, flag, irq, err;
    logic [1:0] dir = 2'h3, pout = 2'h0;
    sbtc_pkg::sbtc_pins_t pins;
    logic [15:0] cnt, c0;
    int failures = 0, checks = 0, n, h;
    always #10 mclk_i = ~mclk_i;
    sbtc_top #(.CYCLE_DIV(DIV)) u_dut (.mclk_i(mclk_i), .reset_i(reset_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .sleep_i(sleep),
        .ext_count_clock_pin_i(ext_pin), .crystal_clk_i(xtal), .port_c_direction_i(dir),
        .port_c_out_i(pout), .port_c_pins_o(pins), .aux_osc_enable_o(osc_en),
        .count_o(cnt), .overflow_flag_o(flag), .overflow_irq_o(irq));
    sbtc_crystal_model #(.HALF(5)) u_xtal (.mclk_i(mclk_i), .enable_i(osc_en), .clk_o(xtal));
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic final_report();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic tmo();
        failures++;
        $display("Error wait limit expired");
        final_report();
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge mclk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_i);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk_i);
            k++;
            if (k > 20)
                tmo();
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // cycles until the count next moves
    task automatic wait_chg(output int cyc);
        logic [15:0] p = cnt;
        cyc = 0;
        do
        begin
            @(posedge mclk_i);
            cyc++;
            if (cyc > 400)
                tmo();
        end
        while (cnt === p);
    endtask
    initial
    begin
        repeat (8) @(posedge mclk_i);
        reset_i <= 1'b0;
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b0, 8'h10 + 8'(4 * i), 32'h0);
            chk("reset value", rd, 32'h0);
            chk("slave error", {31'h0, err}, {31'h0, i == 4});
        end
        lfsr = next_rand(lfsr);
        dir <= lfsr[1:0];
        pout <= lfsr[3:2];
        @(posedge mclk_i);
        chk("pin enable", pins.oe, {~dir});
        chk("pin out", pins.out, pout);
        apb(1'b1, 8'h10, lfsr);
        apb(1'b0, 8'h10, 32'h0);
        chk("control", rd, lfsr & 32'h3f);
        for (int p = 0; p < 4; p++)
        begin
            lfsr = next_rand(lfsr);
            apb(1'b1, 8'h10, {26'h0, 2'(p), 1'b0, lfsr[0], 2'h1});
            repeat (3) wait_chg(n);
            chk("tick interval", n, DIV << p);
        end
        apb(1'b1, 8'h10, 32'h0);
        @(posedge mclk_i);
        c0 = cnt;
        repeat (40) @(posedge mclk_i);
        chk("held count", cnt, c0);
        apb(1'b1, 8'h14, 32'hfffd);
        apb(1'b1, 8'h10, 32'h1);
        n = 0;
        do
        begin
            c0 = cnt;
            @(posedge mclk_i);
            n++;
            if (n > 100)
                tmo();
        end
        while (cnt !== 16'h0000);
        chk("wrap from", c0, 32'hffff);
        @(posedge mclk_i);
        chk("flag", flag, 1'b1);
        chk("irq masked", irq, 1'b0);
        apb(1'b1, 8'h10, 32'h0);
        apb(1'b1, 8'h1c, 32'h1);
        @(posedge mclk_i);
        chk("irq", irq, 1'b1);
        chk("flag latched", flag, 1'b1);
        apb(1'b1, 8'h18, 32'h0);
        @(posedge mclk_i);
        chk("flag clear", flag, 1'b0);
        chk("irq clear", irq, 1'b0);
        for (int s = 0; s < 2; s++)
        begin
            apb(1'b1, 8'h10, {29'h0, s == 0, 2'h3});
            lfsr = next_rand(lfsr);
            h = 3 + lfsr[1:0];
            repeat (4) @(posedge mclk_i);
            c0 = cnt;
            repeat (6)
            begin
                repeat (h) @(posedge mclk_i);
                ext_pin <= 1'b1;
                repeat (h) @(posedge mclk_i);
                ext_pin <= 1'b0;
            end
            repeat (6) @(posedge mclk_i);
            chk("edge count", 16'(cnt - c0), 32'h6);
        end
        apb(1'b1, 8'h10, 32'hf);
        @(posedge mclk_i);
        chk("osc on", osc_en, 1'b1);
        chk("pins released", pins.oe, 32'h0);
        sleep <= 1'b1;
        // start-up delay before trusting the crystal
        repeat (30) @(posedge mclk_i);
        c0 = cnt;
        repeat (100) @(posedge mclk_i);
        chk("crystal count", 16'(cnt - c0), 32'ha);
        sleep <= 1'b0;
        apb(1'b1, 8'h10, 32'h7);
        @(posedge mclk_i);
        chk("osc off", osc_en, 1'b0);
        chk("pins restored", pins.oe, {~dir});
        repeat (4) @(posedge mclk_i);
        c0 = cnt;
        repeat (40) @(posedge mclk_i);
        chk("stopped crystal", cnt, c0);
        final_report();
    end
endmodule
`default_nettype wire

/* File: rtl/sbtc_input_path.sv */
// clock source selection and external edge detection for the counter input
`timescale 1ns/1ps
`default_nettype none
module sbtc_input_path
(
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic ext_in_i,
    input wire logic src_sel_i,
    input wire logic sync_bypass_i,
    input wire logic cycle_tick_i,
    input wire logic sleep_i,
    output logic tick_o
);
    logic sync_1;
    logic sync_2;
    logic sync_3;
    logic async_q;
    logic sync_edge;
    logic async_edge;

    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            sync_1 <= 1'b0;
            sync_2 <= 1'b0;
            sync_3 <= 1'b0;
        end
        else
        begin
            sync_1 <= ext_in_i;
            sync_2 <= sync_1;
            sync_3 <= sync_2;
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
            async_q <= 1'b0;
        else
            async_q <= ext_in_i;
    end

    // the synchronised path stops with the internal clock in sleep
    assign sync_edge = sync_2 && !sync_3 && !sleep_i;
    assign async_edge = ext_in_i && !async_q;
    assign tick_o = !src_sel_i ? cycle_tick_i :
        (sync_bypass_i ? async_edge : sync_edge);

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    sequence s_sync_mode;
        src_sel_i && !sync_bypass_i && !sleep_i;
    endsequence

    a_internal_source: assert property (!src_sel_i |-> tick_o == cycle_tick_i)
        else $error("internal source not following instruction cycle");
    a_async_edge: assert property (src_sel_i && sync_bypass_i && $rose(ext_in_i) |-> tick_o)
        else $error("unsynchronised rising edge missed");
    a_sync_edge_delay: assert property
        (($rose(ext_in_i) and s_sync_mode) ##1 s_sync_mode ##1 s_sync_mode |-> tick_o)
        else $error("synchronised edge not seen two cycles later");
endmodule
`default_nettype wire

/* File: rtl/sbtc_top.sv */
// sixteen-bit timer/counter with apb register access
// Overview of operation
// - setting oscillator enable starts the built-in crystal oscillator
// - clearing oscillator enable stops the crystal oscillator
// - enabled oscillator makes both shared pins inputs, ignoring port direction
// - with external source, sync bit 1 bypasses synchroniser, 0 synchronises
// - source select 0 uses internal clock and ignores the sync bit
// - run bit 1 counts, 0 stops and holds the count
// - crystal oscillator keeps running during sleep
// - counter counts 0000h up to ffffh then wraps to 0000h
// - every overflow sets the latched overflow flag, flag bit 0
// - overflow interrupt raised only while enable bit 0 is set
// - internal source advances once per instruction cycle before prescaling
// - external source advances on each rising edge of external input, except in synchronised mode during sleep
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module sbtc_top
#(
    parameter int CYCLE_DIV = sbtc_pkg::CYCLE_DIV
)
(
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [sbtc_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [sbtc_pkg::DATA_W-1:0] pwdata_i,
    output logic [sbtc_pkg::DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic sleep_i,
    input wire logic ext_count_clock_pin_i,
    input wire logic crystal_clk_i,
    input wire logic [1:0] port_c_direction_i,
    input wire logic [1:0] port_c_out_i,
    output sbtc_pkg::sbtc_pins_t port_c_pins_o,
    output logic aux_osc_enable_o,
    output logic [sbtc_pkg::COUNT_W-1:0] count_o,
    output logic overflow_flag_o,
    output logic overflow_irq_o
);
    localparam int DIV_W = (CYCLE_DIV > 1) ? $clog2(CYCLE_DIV) : 1;

    sbtc_pkg::sbtc_ctrl_t ctrl;
    logic [sbtc_pkg::COUNT_W-1:0] count;
    logic flag;
    logic irq_enable;
    logic [DIV_W-1:0] cyc_cnt;
    logic cycle_tick;
    logic [sbtc_pkg::PRESC_W-1:0] pre_cnt;
    logic [sbtc_pkg::PRESC_W-1:0] pre_mask;
    logic ext_source;
    logic in_tick;
    logic inc;
    logic wrap;
    logic setup;
    logic access_wr;
    logic mapped;
    logic ctrl_wr;
    logic count_wr;
    logic flag_wr;
    logic ie_wr;
    logic [sbtc_pkg::DATA_W-1:0] next_rdata;
    logic [sbtc_pkg::COUNT_W-1:0] wr_count;

    // apb decode; the slave answers with no wait states
    assign setup = psel_i && !penable_i;
    assign access_wr = psel_i && penable_i && pwrite_i;
    assign mapped = (paddr_i == sbtc_pkg::ADDR_CONTROL) || (paddr_i == sbtc_pkg::ADDR_COUNT)
        || (paddr_i == sbtc_pkg::ADDR_FLAGS) || (paddr_i == sbtc_pkg::ADDR_ENABLES);
    assign ctrl_wr = access_wr && (paddr_i == sbtc_pkg::ADDR_CONTROL);
    assign count_wr = access_wr && (paddr_i == sbtc_pkg::ADDR_COUNT);
    assign flag_wr = access_wr && (paddr_i == sbtc_pkg::ADDR_FLAGS);
    assign ie_wr = access_wr && (paddr_i == sbtc_pkg::ADDR_ENABLES);
    assign pready_o = 1'b1;

    always_comb
    begin
        next_rdata = '0;
        unique case (paddr_i)
            sbtc_pkg::ADDR_CONTROL: next_rdata[sbtc_pkg::CTRL_W-1:0] = ctrl;
            sbtc_pkg::ADDR_COUNT: next_rdata[sbtc_pkg::COUNT_W-1:0] = count;
            sbtc_pkg::ADDR_FLAGS: next_rdata[sbtc_pkg::FLAG_BIT] = flag;
            sbtc_pkg::ADDR_ENABLES: next_rdata[sbtc_pkg::IE_BIT] = irq_enable;
            default: next_rdata = '0;
        endcase
    end

    // read data and error are captured in the setup cycle
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            prdata_o <= '0;
            pslverr_o <= 1'b0;
        end
        else if (setup)
        begin
            prdata_o <= pwrite_i ? '0 : next_rdata;
            pslverr_o <= !mapped;
        end
        else if (!psel_i)
        begin
            prdata_o <= '0;
            pslverr_o <= 1'b0;
        end
    end

    // control register
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
            ctrl <= sbtc_pkg::CTRL_RESET;
        else if (ctrl_wr)
            ctrl <= pwdata_i[sbtc_pkg::CTRL_W-1:0];
    end

    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
            irq_enable <= 1'b0;
        else if (ie_wr)
            irq_enable <= pwdata_i[sbtc_pkg::IE_BIT];
    end

    // oscillator enable is independent of sleep, so it keeps running
    assign aux_osc_enable_o = ctrl.aux_osc_enable;

    // shared pins become oscillator inputs while the oscillator runs
    always_comb
    begin
        port_c_pins_o.out = port_c_out_i;
        if (ctrl.aux_osc_enable)
            port_c_pins_o.oe = 2'h0;
        else
            port_c_pins_o.oe = ~port_c_direction_i;
    end

    // instruction cycle divider, halted in sleep
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
            cyc_cnt <= '0;
        else if (!sleep_i)
        begin
            if (cycle_tick)
                cyc_cnt <= '0;
            else
                cyc_cnt <= cyc_cnt + 1'b1;
        end
    end
    assign cycle_tick = !sleep_i && (cyc_cnt == DIV_W'(CYCLE_DIV - 1));

    // external input is the crystal clock while the oscillator runs
    assign ext_source = ctrl.aux_osc_enable ? crystal_clk_i : ext_count_clock_pin_i;

    sbtc_input_path u_input_path
    (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .ext_in_i(ext_source),
        .src_sel_i(ctrl.clock_source_select),
        .sync_bypass_i(ctrl.ext_clock_sync_bypass),
        .cycle_tick_i(cycle_tick),
        .sleep_i(sleep_i),
        .tick_o(in_tick)
    );

    // prescaler: pass one of every 1, 2, 4 or 8 input ticks
    always_comb
    begin
        pre_mask = '0;
        for (int i = 0; i < sbtc_pkg::PRESC_W; i++)
        begin
            pre_mask[i] = (i < int'(ctrl.prescale));
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
            pre_cnt <= '0;
        else if (ctrl.counter_run && in_tick)
            pre_cnt <= pre_cnt + 1'b1;
    end

    assign inc = ctrl.counter_run && in_tick && ((pre_cnt & pre_mask) == pre_mask);
    assign wrap = inc && (count == sbtc_pkg::COUNT_MAX) && !count_wr;

    // write data as the counter takes it
    assign wr_count = pwdata_i[sbtc_pkg::COUNT_W-1:0];

    // counter; a software write wins over an increment
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
            count <= sbtc_pkg::COUNT_RESET;
        else if (count_wr)
            count <= wr_count;
        else if (inc)
            count <= count + 1'b1;
    end

    // overflow flag: a wrap in the clearing cycle still sets it
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
            flag <= 1'b0;
        else if (wrap)
            flag <= 1'b1;
        else if (flag_wr)
            flag <= pwdata_i[sbtc_pkg::FLAG_BIT];
    end

    assign count_o = count;
    assign overflow_flag_o = flag;
    assign overflow_irq_o = flag && irq_enable;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    sequence s_osc_on_write;
        ctrl_wr && pwdata_i[sbtc_pkg::OSC_BIT];
    endsequence

    sequence s_osc_off_write;
        ctrl_wr && !pwdata_i[sbtc_pkg::OSC_BIT];
    endsequence

    a_osc_start: assert property (s_osc_on_write |=> aux_osc_enable_o)
        else $error("oscillator not started by enable write");
    a_osc_stop: assert property (s_osc_off_write |=> !aux_osc_enable_o)
        else $error("oscillator not stopped by disable write");
    a_pin_override: assert property (aux_osc_enable_o |-> port_c_pins_o.oe == 2'h0)
        else $error("shared pin driven while oscillator enabled");
    a_sleep_osc_runs: assert property
        (aux_osc_enable_o && sleep_i && !ctrl_wr |=> aux_osc_enable_o)
        else $error("oscillator stopped during sleep");
    a_run_holds: assert property (!ctrl.counter_run && !count_wr |=> $stable(count))
        else $error("count changed while stopped");
    a_wrap_sets_flag: assert property
        (inc && count == sbtc_pkg::COUNT_MAX && !count_wr |=> count == '0 && flag)
        else $error("wrap to zero without overflow flag");
    a_irq_masked: assert property (!irq_enable |-> !overflow_irq_o)
        else $error("interrupt raised while disabled");
    a_prescale_eight: assert property
        (inc && ctrl.prescale == sbtc_pkg::PRESC_1_8 |-> pre_cnt == sbtc_pkg::PRESC_FULL)
        else $error("1:8 prescale passed a tick early");
    a_flag_sticky: assert property
        (flag && !(flag_wr && !pwdata_i[sbtc_pkg::FLAG_BIT]) |=> flag)
        else $error("overflow flag dropped without clear");

    // apb answer: read data and error stand from the setup edge
    sequence s_read_setup;
        setup && !pwrite_i;
    endsequence

    a_read_count: assert property
        (s_read_setup ##0 (paddr_i == sbtc_pkg::ADDR_COUNT)
        |=> prdata_o[sbtc_pkg::COUNT_W-1:0] == $past(count))
        else $error("count read did not return the counter");
    a_write_reads_zero: assert property (setup && pwrite_i |=> prdata_o == '0)
        else $error("read data not zero during a write");
    a_unmapped_error: assert property (setup && !mapped |=> pslverr_o)
        else $error("unmapped access without slave error");
    a_idle_bus_quiet: assert property (!psel_i |=> prdata_o == '0 && !pslverr_o)
        else $error("read data or error left standing while idle");

    // counter step, load and hold
    a_count_load: assert property (count_wr |=> count == $past(wr_count))
        else $error("count write did not load the counter");
    a_count_step: assert property
        (inc && !count_wr |=> count == $past(count) + 1'b1)
        else $error("count did not advance by one");
    a_count_idle: assert property
        (!inc && !count_wr |=> $stable(count))
        else $error("count moved without an increment");
    a_step_needs_run: assert property (inc |-> ctrl.counter_run)
        else $error("count advanced while stopped");

    // flag, interrupt, shared pin, crystal source and sleep checks
    a_flag_clear: assert property
        (flag_wr && !pwdata_i[sbtc_pkg::FLAG_BIT] && !wrap |=> !flag)
        else $error("overflow flag not cleared by software");
    a_flag_set_write: assert property (flag_wr && pwdata_i[sbtc_pkg::FLAG_BIT] |=> flag)
        else $error("overflow flag not set by software");
    a_flag_only_wrap: assert property
        (!flag && !wrap && !(flag_wr && pwdata_i[sbtc_pkg::FLAG_BIT]) |=> !flag)
        else $error("overflow flag rose without a wrap");
    a_irq_raised: assert property (flag && irq_enable |-> overflow_irq_o)
        else $error("enabled overflow raised no interrupt");
    a_pins_follow: assert property
        (!aux_osc_enable_o |-> port_c_pins_o.oe == ~port_c_direction_i)
        else $error("shared pin enable not following port direction");
    a_crystal_feeds: assert property
        (aux_osc_enable_o |-> ext_source == crystal_clk_i)
        else $error("external input not taken from crystal");
    a_sleep_no_cycle: assert property (sleep_i |-> !cycle_tick)
        else $error("instruction cycle ticked during sleep");
endmodule
`default_nettype wire

/* File: shared/sbtc_pkg.sv */
// constants, register map and carrier types of the sixteen-bit timer/counter
package sbtc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int COUNT_W = 16;
    localparam int PRESC_W = 3;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_COUNT = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_FLAGS = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_ENABLES = 8'h1c;
    localparam int OSC_BIT = 3;
    localparam int FLAG_BIT = 0;
    localparam int IE_BIT = 0;
    localparam logic [COUNT_W-1:0] COUNT_MAX = 16'hffff;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
    localparam logic [1:0] PRESC_1_8 = 2'h3;
    localparam logic [PRESC_W-1:0] PRESC_FULL = 3'h7;
    // internal instruction cycle, in ns, and the system clock period
    localparam int INSTR_CYCLE_NS = 80;
    localparam int CLK_PERIOD_NS = 20;
    localparam int CYCLE_DIV = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // control register layout, bit 5 down to bit 0
    typedef struct packed {
        logic [1:0] prescale;
        logic aux_osc_enable;
        logic ext_clock_sync_bypass;
        logic clock_source_select;
        logic counter_run;
    } sbtc_ctrl_t;
    localparam sbtc_ctrl_t CTRL_RESET = 6'h00;
    localparam int CTRL_W = $bits(sbtc_ctrl_t);

    // drive of the two shared port pins
    typedef struct packed {
        logic [1:0] out;
        logic [1:0] oe;
    } sbtc_pins_t;
endpackage
